// File: pkg/sdt_pkg.sv
package sdt_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_CTRL_A = 6'h00;
   localparam logic [5:0] IDX_OUT_EN = 6'h01;
   localparam logic [5:0] IDX_OUT_VAL = 6'h02;
   localparam logic [5:0] IDX_SPLIT = 6'h03;
   localparam logic [5:0] IDX_CMD_CLR = 6'h04;
   localparam logic [5:0] IDX_CMD_SET = 6'h05;
   localparam logic [5:0] IDX_INT_EN = 6'h0a;
   localparam logic [5:0] IDX_FLAGS = 6'h0b;
   localparam logic [5:0] IDX_DEBUG = 6'h0e;
   localparam logic [5:0] IDX_LO_CNT = 6'h20;
   localparam logic [5:0] IDX_HI_CNT = 6'h21;
   localparam logic [5:0] IDX_LO_PER = 6'h26;
   localparam logic [5:0] IDX_HI_PER = 6'h27;
   localparam logic [5:0] IDX_LO_CMP0 = 6'h28;
   localparam logic [5:0] IDX_HI_CMP0 = 6'h29;
   localparam logic [5:0] IDX_LO_CMP1 = 6'h2a;
   localparam logic [5:0] IDX_HI_CMP1 = 6'h2b;
   localparam logic [5:0] IDX_LO_CMP2 = 6'h2c;
   localparam logic [5:0] IDX_HI_CMP2 = 6'h2d;

   // ----------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------
   localparam int POS_ENABLE = 0;
   localparam int POS_CLOCK_PRESCALE_SELECT = 1;
   localparam int POS_SPLIT = 0;
   localparam int POS_RUN_WHILE_HALTED = 0;
   localparam int POS_TARGET = 0;
   localparam int POS_CMD = 2;
   localparam int POS_LOW_HALF_UNDERFLOW = 0;
   localparam int POS_HIGH_HALF_UNDERFLOW = 1;
   localparam int POS_LCMP = 4;
   localparam int POS_HCH = 4;
   localparam logic [7:0] OUT_MASK = 8'h77;
   localparam logic [7:0] INT_MASK = 8'h73;

   // ----------------------------------------------------------------
   // Commands and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_RESTART = 2'h2;
   localparam logic [1:0] CMD_HARD_RESET = 2'h3;
   localparam logic [1:0] TARGET_BOTH = 2'h3;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_PER = 8'hff;
   localparam logic [9:0] PRESC_ONE = 10'h001;

   // Prescaler masks for codes 0..7: divide by 1,2,4,8,16,64,256,1024
   localparam logic [7:0][9:0] PRESC_MASK = {
      10'h3ff, 10'h0ff, 10'h03f, 10'h00f, 10'h007, 10'h003, 10'h001, 10'h000};

   // ----------------------------------------------------------------
   // Bus carriers and state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } sdt_ahb_req_t;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } sdt_ahb_rsp_t;

   typedef struct packed {
      logic wr_pend;
      logic rd_pend;
      logic [5:0] idx;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic [2:0] clock_prescale_select;
      logic enable;
      logic [7:0] cmp_out_en;
      logic [7:0] out_val;
      logic split;
      logic [1:0] target;
      logic [7:0] int_en;
      logic [7:0] flags;
      logic run_while_halted;
      logic [9:0] presc;
      logic [7:0] lo_cnt;
      logic [7:0] hi_cnt;
      logic [7:0] lo_per;
      logic [7:0] hi_per;
      logic [2:0][7:0] lo_cmp;
      logic [2:0][7:0] hi_cmp;
      logic [5:0] wave;
   } sdt_state_t;

endpackage

// File: core/sdt_core.sv
// Function
// - While disabled, output-value bits drive each waveform pin directly.
// - Split-select bit in control register 0x03 makes two 8-bit counters.
// - Split mode swaps in the byte-wide counter, period and compare map.
// - Writing one to the clear alias 0x04 clears just that bit.
// - Writing one to the set alias 0x05 sets just that bit.
// - Command field bits 3:2 of both aliases always read zero.
// - Command 0 none, 1 reserved, 2 restart, 3 hard reset unless enabled.
// - Target field bits 1:0: 0 none, 1-2 reserved, 3 both halves.
// - Interrupt-enable bit n+4 at 0x0A enables low compare channel n.
// - Interrupt-enable bit 1 high underflow, bit 0 low underflow.
// - Low compare flag n at 0x0B sets when low count matches compare n.
// - Compare flags stay set until software writes one to them or a hard-reset command clears them.
// - Flag bit 1 sets on high-half underflow, cleared by writing one.
// - Flag bit 0 sets on low-half underflow, cleared by writing one.
// - Run-in-debug bit at 0x0E clear halts counting while CPU halted.
// - Compare output enable lets the comparator override the pin value.
// - Clock-select codes 0-7 divide by 1,2,4,8,16,64,256,1024.
// - Each half's compares are checked continuously against its count.
module sdt_core (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire sdt_pkg::sdt_ahb_req_t ahb_req,
   output sdt_pkg::sdt_ahb_rsp_t ahb_rsp,
   // Debug state of the processor, same clock
   input wire logic cpu_halted,
   // Waveform pins: low channels 2:0, high channels 5:3
   output logic [5:0] waveform_output_pin
);

   // ----------------------------------------------------------------
   // State and shared terms
   // ----------------------------------------------------------------
   sdt_pkg::sdt_state_t st_r;
   sdt_pkg::sdt_state_t st_nxt;
   logic [7:0] wdat;
   logic wr_now;
   logic accept;
   logic run;
   logic tick;
   logic lo_unf;
   logic hi_unf;
   logic cmd_go;
   logic do_restart;
   logic do_hard_reset;
   logic [2:0] lo_match;
   logic [2:0] hi_match;
   logic [2:0] lo_wave;
   logic [2:0] hi_wave;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic [7:0] rdata;

   assign wdat = ahb_req.hwdata[7:0];
   assign wr_now = st_r.wr_pend;
   assign accept = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

   // Halted CPU freezes the halves unless run-in-debug is set
   assign run = st_r.enable & st_r.split & ~(cpu_halted & ~st_r.run_while_halted);
   assign tick = run
      & ((st_r.presc & sdt_pkg::PRESC_MASK[st_r.clock_prescale_select])
         == sdt_pkg::PRESC_MASK[st_r.clock_prescale_select]);
   assign lo_unf = tick & (st_r.lo_cnt == sdt_pkg::RST_REG);
   assign hi_unf = tick & (st_r.hi_cnt == sdt_pkg::RST_REG);

   // Target must name both halves, else the command does nothing
   assign cmd_go = wr_now & ((st_r.idx == sdt_pkg::IDX_CMD_CLR) | (st_r.idx == sdt_pkg::IDX_CMD_SET))
      & (wdat[sdt_pkg::POS_TARGET +: 2] == sdt_pkg::TARGET_BOTH);
   assign do_restart = cmd_go & (wdat[sdt_pkg::POS_CMD +: 2] == sdt_pkg::CMD_RESTART);
   assign do_hard_reset = cmd_go & ~st_r.enable
      & (wdat[sdt_pkg::POS_CMD +: 2] == sdt_pkg::CMD_HARD_RESET);

   // ----------------------------------------------------------------
   // Comparators, one per channel and half
   // ----------------------------------------------------------------
   genvar n;
   generate
      for (n = 0; n < 3; n++) begin : g_chan
         assign lo_match[n] = st_r.lo_cnt == st_r.lo_cmp[n];
         assign hi_match[n] = st_r.hi_cnt == st_r.hi_cmp[n];
         // Pin follows comparator only when enabled and overridden
         assign lo_wave[n] = (st_r.enable & st_r.cmp_out_en[n])
            ? (st_r.lo_cnt <= st_r.lo_cmp[n]) : st_r.out_val[n];
         assign hi_wave[n] = (st_r.enable & st_r.cmp_out_en[n + sdt_pkg::POS_HCH])
            ? (st_r.hi_cnt <= st_r.hi_cmp[n])
            : st_r.out_val[n + sdt_pkg::POS_HCH];
         assign flag_set[n + sdt_pkg::POS_LCMP] = tick & lo_match[n];
      end
   endgenerate

   // Only low compares and the two underflows own flags
   assign flag_set[7] = 1'b0;
   assign flag_set[3:2] = 2'b00;
   assign flag_set[sdt_pkg::POS_HIGH_HALF_UNDERFLOW] = hi_unf;
   assign flag_set[sdt_pkg::POS_LOW_HALF_UNDERFLOW] = lo_unf;
   assign flag_clr = (wr_now & (st_r.idx == sdt_pkg::IDX_FLAGS))
      ? (wdat & sdt_pkg::INT_MASK) : 8'h00;

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   always_comb begin
      rdata = 8'h00;
      case (st_r.idx)
         sdt_pkg::IDX_CTRL_A: rdata = {4'h0, st_r.clock_prescale_select, st_r.enable};
         sdt_pkg::IDX_OUT_EN: rdata = st_r.cmp_out_en;
         sdt_pkg::IDX_OUT_VAL: rdata = st_r.out_val;
         sdt_pkg::IDX_SPLIT: rdata = {7'h00, st_r.split};
         // Command bits are never stored, so they read zero
         sdt_pkg::IDX_CMD_CLR, sdt_pkg::IDX_CMD_SET: rdata = {6'h00, st_r.target};
         sdt_pkg::IDX_INT_EN: rdata = st_r.int_en;
         sdt_pkg::IDX_FLAGS: rdata = st_r.flags;
         sdt_pkg::IDX_DEBUG: rdata = {7'h00, st_r.run_while_halted};
         default: rdata = 8'h00;
      endcase
      // Byte-wide half map exists only in split mode
      if (st_r.split) begin
         case (st_r.idx)
            sdt_pkg::IDX_LO_CNT: rdata = st_r.lo_cnt;
            sdt_pkg::IDX_HI_CNT: rdata = st_r.hi_cnt;
            sdt_pkg::IDX_LO_PER: rdata = st_r.lo_per;
            sdt_pkg::IDX_HI_PER: rdata = st_r.hi_per;
            sdt_pkg::IDX_LO_CMP0: rdata = st_r.lo_cmp[0];
            sdt_pkg::IDX_HI_CMP0: rdata = st_r.hi_cmp[0];
            sdt_pkg::IDX_LO_CMP1: rdata = st_r.lo_cmp[1];
            sdt_pkg::IDX_HI_CMP1: rdata = st_r.hi_cmp[1];
            sdt_pkg::IDX_LO_CMP2: rdata = st_r.lo_cmp[2];
            sdt_pkg::IDX_HI_CMP2: rdata = st_r.hi_cmp[2];
            default: rdata = rdata;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.hresp = 1'b0;
      st_nxt.wave = {hi_wave, lo_wave};

      // Counting first, so a bus write below wins over it
      if (run) begin
         st_nxt.presc = st_r.presc + sdt_pkg::PRESC_ONE;
      end
      if (tick) begin
         st_nxt.lo_cnt = lo_unf ? st_r.lo_per : st_r.lo_cnt - 8'h01;
         st_nxt.hi_cnt = hi_unf ? st_r.hi_per : st_r.hi_cnt - 8'h01;
      end

      // Reads take one wait state so data always comes from a flop
      st_nxt.wr_pend = 1'b0;
      if (st_r.rd_pend) begin
         st_nxt.rd_pend = 1'b0;
         st_nxt.hready = 1'b1;
         st_nxt.hrdata = {24'h000000, rdata};
      end
      if (accept) begin
         st_nxt.idx = ahb_req.haddr[7:2];
         st_nxt.wr_pend = ahb_req.hwrite;
         st_nxt.rd_pend = ~ahb_req.hwrite;
         st_nxt.hready = ahb_req.hwrite;
      end

      if (wr_now) begin
         case (st_r.idx)
            sdt_pkg::IDX_CTRL_A: begin
               st_nxt.clock_prescale_select = wdat[sdt_pkg::POS_CLOCK_PRESCALE_SELECT +: 3];
               st_nxt.enable = wdat[sdt_pkg::POS_ENABLE];
            end
            sdt_pkg::IDX_OUT_EN: st_nxt.cmp_out_en = wdat & sdt_pkg::OUT_MASK;
            sdt_pkg::IDX_OUT_VAL: st_nxt.out_val = wdat & sdt_pkg::OUT_MASK;
            sdt_pkg::IDX_SPLIT: st_nxt.split = wdat[sdt_pkg::POS_SPLIT];
            sdt_pkg::IDX_CMD_CLR: st_nxt.target = st_r.target & ~wdat[1:0];
            sdt_pkg::IDX_CMD_SET: st_nxt.target = st_r.target | wdat[1:0];
            sdt_pkg::IDX_INT_EN: st_nxt.int_en = wdat & sdt_pkg::INT_MASK;
            sdt_pkg::IDX_DEBUG: st_nxt.run_while_halted = wdat[sdt_pkg::POS_RUN_WHILE_HALTED];
            // Leave idx alone: a back-to-back address phase may be loading it
            default: begin
            end
         endcase
         if (st_r.split) begin
            case (st_r.idx)
               sdt_pkg::IDX_LO_CNT: st_nxt.lo_cnt = wdat;
               sdt_pkg::IDX_HI_CNT: st_nxt.hi_cnt = wdat;
               sdt_pkg::IDX_LO_PER: st_nxt.lo_per = wdat;
               sdt_pkg::IDX_HI_PER: st_nxt.hi_per = wdat;
               sdt_pkg::IDX_LO_CMP0: st_nxt.lo_cmp[0] = wdat;
               sdt_pkg::IDX_HI_CMP0: st_nxt.hi_cmp[0] = wdat;
               sdt_pkg::IDX_LO_CMP1: st_nxt.lo_cmp[1] = wdat;
               sdt_pkg::IDX_HI_CMP1: st_nxt.hi_cmp[1] = wdat;
               sdt_pkg::IDX_LO_CMP2: st_nxt.lo_cmp[2] = wdat;
               sdt_pkg::IDX_HI_CMP2: st_nxt.hi_cmp[2] = wdat;
               default: begin
               end
            endcase
         end
      end

      // Set wins over a same-cycle write-one clear
      st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;

      if (do_restart) begin
         st_nxt.lo_cnt = st_r.lo_per;
         st_nxt.hi_cnt = st_r.hi_per;
         st_nxt.presc = 10'h000;
      end
      // Hard reset only reachable while disabled, so no tick competes
      if (do_hard_reset) begin
         st_nxt.lo_cnt = sdt_pkg::RST_REG;
         st_nxt.hi_cnt = sdt_pkg::RST_REG;
         st_nxt.lo_per = sdt_pkg::RST_PER;
         st_nxt.hi_per = sdt_pkg::RST_PER;
         st_nxt.lo_cmp = '0;
         st_nxt.hi_cmp = '0;
         st_nxt.flags = sdt_pkg::RST_REG;
         st_nxt.presc = 10'h000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
         st_r.hready <= 1'b1;
         st_r.lo_per <= sdt_pkg::RST_PER;
         st_r.hi_per <= sdt_pkg::RST_PER;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ahb_rsp.hreadyout = st_r.hready;
   assign ahb_rsp.hresp = st_r.hresp;
   assign ahb_rsp.hrdata = st_r.hrdata;
   assign waveform_output_pin = st_r.wave;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_rd_issue(logic [5:0] ix);
      st_r.rd_pend && (st_r.idx == ix);
   endsequence

   a_split_map_off: assert property (
      s_rd_issue(sdt_pkg::IDX_LO_CNT) and !st_r.split |=> st_r.hrdata == 32'h0)
      else $error("Half counter visible outside split mode");

   a_alias_cmd_zero: assert property (
      s_rd_issue(sdt_pkg::IDX_CMD_SET) |=> st_r.hready && (st_r.hrdata[3:2] == 2'b00))
      else $error("Command field read back nonzero");

   a_clear_alias: assert property (
      wr_now && (st_r.idx == sdt_pkg::IDX_CMD_CLR) && wdat[0]
      |=> !st_r.target[0] && (st_r.target[1] == $past(st_r.target[1] & ~wdat[1])))
      else $error("Clear alias touched wrong bits");

   a_set_alias: assert property (
      wr_now && (st_r.idx == sdt_pkg::IDX_CMD_SET) && wdat[1]
      |=> st_r.target[1] && (st_r.target[0] == $past(st_r.target[0] | wdat[0])))
      else $error("Set alias touched wrong bits");

   a_cmp_flag_set: assert property (
      tick && lo_match[1] |=> st_r.flags[sdt_pkg::POS_LCMP + 1])
      else $error("Low compare flag missed");

   a_flag_sticky: assert property (
      st_r.flags[sdt_pkg::POS_LCMP] && !flag_clr[sdt_pkg::POS_LCMP] && !do_hard_reset
      |=> st_r.flags[sdt_pkg::POS_LCMP])
      else $error("Compare flag dropped by itself");

   a_high_half_underflow_flag: assert property (
      tick && (st_r.hi_cnt == 8'h00) |=> st_r.flags[sdt_pkg::POS_HIGH_HALF_UNDERFLOW]
         && (st_r.hi_cnt == $past(st_r.hi_per)) || $past(wr_now) || $past(cmd_go))
      else $error("High underflow not flagged");

   a_low_half_underflow_flag: assert property (
      tick && (st_r.lo_cnt == 8'h00) && !wr_now |=> st_r.flags[sdt_pkg::POS_LOW_HALF_UNDERFLOW]
         && (st_r.lo_cnt == $past(st_r.lo_per)))
      else $error("Low underflow not flagged or reloaded");

   a_debug_halt: assert property (
      cpu_halted && !st_r.run_while_halted && !wr_now && !cmd_go |=> $stable(st_r.lo_cnt))
      else $error("Counter moved during debug halt");

   a_idle_pins: assert property (
      !st_r.enable && !wr_now [*2]
      |-> st_r.wave == {st_r.out_val[6:4], st_r.out_val[2:0]})
      else $error("Stopped pins ignore output values");

   a_restart_load: assert property (
      do_restart && !do_hard_reset |=> (st_r.hi_cnt == $past(st_r.hi_per))
         && $stable(st_r.clock_prescale_select))
      else $error("Restart did not reload");

   a_reset_ignored: assert property (
      cmd_go && st_r.enable && (wdat[3:2] == sdt_pkg::CMD_HARD_RESET) && !tick
      |=> $stable(st_r.lo_per))
      else $error("Hard reset acted while enabled");

   a_prescale_rate: assert property (
      run && (st_r.clock_prescale_select == 3'h1) && tick |=> !tick)
      else $error("Divide-by-two ticked twice in a row");

endmodule

// File: dv/tb_top.sv
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Byte addresses of the registers used here
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL = {sdt_pkg::IDX_CTRL_A, 2'b00};
   localparam logic [7:0] A_OEN = {sdt_pkg::IDX_OUT_EN, 2'b00};
   localparam logic [7:0] A_OVAL = {sdt_pkg::IDX_OUT_VAL, 2'b00};
   localparam logic [7:0] A_SPLIT = {sdt_pkg::IDX_SPLIT, 2'b00};
   localparam logic [7:0] A_CLR = {sdt_pkg::IDX_CMD_CLR, 2'b00};
   localparam logic [7:0] A_SET = {sdt_pkg::IDX_CMD_SET, 2'b00};
   localparam logic [7:0] A_IEN = {sdt_pkg::IDX_INT_EN, 2'b00};
   localparam logic [7:0] A_FLG = {sdt_pkg::IDX_FLAGS, 2'b00};
   localparam logic [7:0] A_DBG = {sdt_pkg::IDX_DEBUG, 2'b00};
   localparam logic [7:0] A_LOW_HALF_COUNT = {sdt_pkg::IDX_LO_CNT, 2'b00};
   localparam logic [7:0] A_LPER = {sdt_pkg::IDX_LO_PER, 2'b00};
   localparam logic [7:0] A_HPER = {sdt_pkg::IDX_HI_PER, 2'b00};
   localparam logic [7:0] A_CMP0 = {sdt_pkg::IDX_LO_CMP0, 2'b00};
   localparam logic [7:0] A_CMP1 = {sdt_pkg::IDX_LO_CMP1, 2'b00};
   localparam logic [7:0] A_CMP2 = {sdt_pkg::IDX_LO_CMP2, 2'b00};

   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic cpu_halted = 1'b0;
   sdt_pkg::sdt_ahb_req_t req;
   sdt_pkg::sdt_ahb_rsp_t rsp;
   logic [5:0] pins;
   int num_errors = 0;
   int comparisons = 0;

   // Single slave, so its ready is the bus ready
   assign req = {hsel, haddr, htrans, hwrite, hsize, hwdata, rsp.hreadyout};

   sdt_core dut_u (
      .hclk(hclk),
      .hresetn(hresetn),
      .ahb_req(req),
      .ahb_rsp(rsp),
      .cpu_halted(cpu_halted),
      .waveform_output_pin(pins)
   );

   initial begin
      forever #20 hclk = ~hclk;
   end

   // ----------------------------------------------------------------
   // Bus master
   // ----------------------------------------------------------------
   task automatic finish_test();
      if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Bounded wait for hready high at a rising edge
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (rsp.hreadyout !== 1'b1 && n < 20);
      if (rsp.hreadyout !== 1'b1) begin
         num_errors++;
         finish_test();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      wait_ready();
      rd = rsp.hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 8'h00, v);
      `CHK(nm, {24'h00_0000, exp}, v)
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_and_map();
      rd_chk("split reset", A_SPLIT, 8'h00);
      rd_chk("clr reset", A_CLR, 8'h00);
      rd_chk("set reset", A_SET, 8'h00);
      rd_chk("ien reset", A_IEN, 8'h00);
      rd_chk("flags reset", A_FLG, 8'h00);
      rd_chk("debug reset", A_DBG, 8'h00);
      rd_chk("unmapped", 8'h3c, 8'h00);
      wr(A_LPER, 8'h12);
      rd_chk("lper unsplit", A_LPER, 8'h00);
      rd_chk("low_half_count unsplit", A_LOW_HALF_COUNT, 8'h00);
      wr(A_SPLIT, 8'h01);
      rd_chk("split bit", A_SPLIT, 8'h01);
      rd_chk("lper split", A_LPER, 8'hff);
      wr(A_IEN, 8'hff);
      rd_chk("ien mask", A_IEN, 8'h73);
      wr(A_IEN, 8'h00);
   endtask

   task automatic t_alias();
      wr(A_SET, 8'h01);
      rd_chk("set bit0", A_CLR, 8'h01);
      wr(A_SET, 8'h02);
      rd_chk("set bit1", A_SET, 8'h03);
      wr(A_CLR, 8'h01);
      rd_chk("clr bit0", A_SET, 8'h02);
      wr(A_SET, 8'h04);
      rd_chk("cmd reads zero", A_SET, 8'h02);
      wr(A_CLR, 8'h0a);
      rd_chk("cmd zero clr", A_CLR, 8'h00);
   endtask

   task automatic t_count_flags();
      wr(A_LPER, 8'h03);
      wr(A_HPER, 8'h05);
      wr(A_LOW_HALF_COUNT, 8'h00);
      wr(A_CMP0, 8'h01);
      wr(A_CMP1, 8'h02);
      wr(A_CMP2, 8'hfe);
      wr(A_CTRL, 8'h01);
      repeat (40) @(posedge hclk);
      wr(A_CTRL, 8'h00);
      rd_chk("flags run", A_FLG, 8'h33);
      rd_chk("flags stay", A_FLG, 8'h33);
      wr(A_FLG, 8'h01);
      rd_chk("w1c low", A_FLG, 8'h32);
      wr(A_FLG, 8'h30);
      rd_chk("w1c cmp", A_FLG, 8'h02);
      wr(A_FLG, 8'h02);
      rd_chk("w1c high", A_FLG, 8'h00);
   endtask

   task automatic t_commands();
      wr(A_LPER, 8'h80);
      wr(A_LOW_HALF_COUNT, 8'h10);
      wr(A_SET, 8'h07);
      rd_chk("reserved cmd", A_LOW_HALF_COUNT, 8'h10);
      wr(A_CLR, 8'h08);
      rd_chk("no target", A_LOW_HALF_COUNT, 8'h10);
      wr(A_SET, 8'h0b);
      rd_chk("restart cnt", A_LOW_HALF_COUNT, 8'h80);
      rd_chk("restart per", A_LPER, 8'h80);
      // Divide by 1024: no tick can land within this short run
      wr(A_CTRL, 8'h0f);
      repeat (100) @(posedge hclk);
      wr(A_CTRL, 8'h00);
      rd_chk("div1024", A_LOW_HALF_COUNT, 8'h80);
      // Divide by two while enabled, so the hard-reset command below is ignored
      wr(A_CTRL, 8'h03);
      wr(A_SET, 8'h0f);
      wr(A_CTRL, 8'h00);
      rd_chk("hard rst ignored", A_LPER, 8'h80);
      wr(A_CLR, 8'h0f);
      rd_chk("hard rst per", A_LPER, 8'hff);
      rd_chk("hard rst cnt", A_LOW_HALF_COUNT, 8'h00);
   endtask

   task automatic t_debug();
      logic [31:0] v;
      cpu_halted <= 1'b1;
      wr(A_LOW_HALF_COUNT, 8'h50);
      wr(A_CTRL, 8'h01);
      repeat (20) @(posedge hclk);
      wr(A_CTRL, 8'h00);
      rd_chk("halted count", A_LOW_HALF_COUNT, 8'h50);
      wr(A_DBG, 8'h01);
      rd_chk("run_while_halted bit", A_DBG, 8'h01);
      wr(A_CTRL, 8'h01);
      repeat (20) @(posedge hclk);
      wr(A_CTRL, 8'h00);
      bus(1'b0, A_LOW_HALF_COUNT, 8'h00, v);
      `CHK("runs halted", 1'b1, v[7:0] != 8'h50)
      cpu_halted <= 1'b0;
      wr(A_DBG, 8'h00);
   endtask

   task automatic t_pins();
      wr(A_OVAL, 8'h25);
      repeat (3) @(posedge hclk);
      `CHK("pins direct", 6'h15, pins)
      wr(A_OVAL, 8'h24);
      wr(A_CMP0, 8'hff);
      wr(A_OEN, 8'h01);
      repeat (3) @(posedge hclk);
      `CHK("pins stopped", 6'h14, pins)
      // Compare of 0xff always holds, so the enabled channel drives high
      wr(A_CTRL, 8'h01);
      repeat (3) @(posedge hclk);
      `CHK("pins override", 6'h15, pins)
      wr(A_CTRL, 8'h00);
   endtask

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset_and_map();
      t_alias();
      t_count_flags();
      t_commands();
      t_debug();
      t_pins();
      finish_test();
   end
endmodule
